// ### core/io_seq_consts.svh
// Constants for the I/O processor address and data sequencer
`ifndef IO_SEQ_CONSTS_SVH
`define IO_SEQ_CONSTS_SVH
`define ADDR_HI_W        8
`define ADDR_W           10
`define BYTE_W           8
`define SEL_W            5
`define SUB_W            3
`define IND_W            8
`define ADDR_RESET       10'h000
`define BYTE_RESET       8'h00
`define IND_RESET        8'h00
`define SUB_FIRST        3'h0
`define SUB_TEN          3'h2
`define SUB_ELEVEN       3'h3
`define SUB_TWELVE       3'h4
`define SUB_THIRTEEN     3'h5
`define SUB_FOURTEEN     3'h6
`define SUB_LAST         3'h7
`define IND_COUNT_ZERO   0
`define IND_ORDER        1
`define IND_OUT          2
`define IND_TERM         3
`define IND_CHAIN        4
`define IND_TIC          5
`define IND_END_DATA     6
`define IND_END_SVC      7
`endif

// ### core/io_seq_pkg.sv
// Types for the I/O processor address and data sequencer
package io_seq_pkg;
  typedef logic [2:0] subphase_t;
  typedef enum logic [2:0] {
    PH_IDLE    = 3'h0,
    PH_CONNECT = 3'h1,
    PH_SETUP   = 3'h3,
    PH_MAIN    = 3'h2
  } svc_state_e;
endpackage : io_seq_pkg

// ### core/io_addr_data_sequencer.sv
// I/O processor address register, outgoing byte register and phase sequencer
//
`timescale 1ns/1ps
`include "io_seq_consts.svh"

module io_addr_data_sequencer (
  // Clock and reset
  input  wire logic                  SYS_CLK,
  input  wire logic                  SYS_RST,
  // Accumulator and CPU register sources
  input  wire logic [7:0]            ACCUM_BYTE,
  input  wire logic [3:0]            TERM_FLAG_BITS,
  // Controller pins (asynchronous)
  input  wire logic [7:0]            FUNCTION_RESPONSE_LINES,
  input  wire logic [7:0]            IN_DATA_LINES,
  input  wire logic                  IN_PARITY_LINE,
  input  wire logic                  PARITY_CHECK_REQ,
  input  wire logic                  SERVICE_CALL,
  input  wire logic                  CONTROLLER_READY,
  // CPU control terms
  input  wire logic                  ADDRESS_FROM_ACCUMULATOR,
  input  wire logic                  INTERRUPT_ACK_INSTRUCTION,
  input  wire logic                  BYTE_FROM_ACCUMULATOR,
  input  wire logic                  TERMINAL_ORDER_COND,
  input  wire logic                  AREA_SET_HI,
  input  wire logic                  AREA_SET_LO,
  input  wire logic                  AREA_CLEAR,
  input  wire logic                  PROCESSOR_OPTION_PRESENT,
  input  wire logic                  CONTEXT_SAVED,
  // Sequencing conditions
  input  wire logic                  IO_READ_COND,
  input  wire logic                  DATA_ORDER_READ,
  input  wire logic                  DATA_OUT_COND,
  input  wire logic                  DATA_IN_COND,
  input  wire logic                  NO_VALID_DATA_OUT,
  input  wire logic                  CHAINING_COND,
  input  wire logic                  ABORT_FLAG,
  input  wire logic                  RESTORE_DONE,
  input  wire logic [6:0]            BRANCH_TERMS,
  input  wire logic                  IND_LOAD,
  input  wire logic [7:0]            IND_VALUE,
  // Fast-memory selects and address
  output logic [9:0]                 CHANNEL_ADDRESS_REG,
  output logic [4:0]                 FAST_MEM_SELECT,
  output logic [1:0]                 FAST_MEM_AREA,
  // Outgoing byte and lines
  output logic [7:0]                 OUTGOING_BYTE_REG,
  output logic                       DATA_PARITY_LINE,
  output logic                       SERVICE_CALL_ACK,
  output logic                       END_DATA_LINE,
  output logic                       END_SERVICE_LINE,
  // Sequencer state
  output logic [3:0]                 MAIN_PHASE,
  output logic [7:0]                 SUBPHASE,
  output logic                       SETUP_PHASE_TERM,
  output logic                       SEQUENTIAL_STEP_ENABLE,
  output logic [7:0]                 INDICATORS,
  output logic [2:0]                 CYCLE_TYPE
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Every controller pin is seen two clocks late, so a service call costs
  // a few cycles more than the bare state count suggests.
  localparam int SW = 20;
  logic [SW-1:0] pin_s1_q;
  logic [SW-1:0] pin_s2_q;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {FUNCTION_RESPONSE_LINES, IN_DATA_LINES, IN_PARITY_LINE,
                   PARITY_CHECK_REQ, SERVICE_CALL, CONTROLLER_READY};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic [7:0] resp_s;
  logic [7:0] din_s;
  logic       dpar_s;
  logic       pchk_s;
  logic       sc_s;
  logic       rdy_s;
  assign {resp_s, din_s, dpar_s, pchk_s, sc_s, rdy_s} = pin_s2_q;

  // The pin bundle must fill the synchroniser exactly
  if (SW != 2 * `BYTE_W + 4) begin : g_sync_width
    $error("pin synchroniser width differs from the pin bundle");
  end

  // ==========================================================================
  // Service call connect and setup
  // ==========================================================================
  io_seq_pkg::svc_state_e svc_q;
  logic                   setup;
  assign setup            = (svc_q == io_seq_pkg::PH_SETUP);
  assign SETUP_PHASE_TERM = setup;
  assign SERVICE_CALL_ACK = (svc_q == io_seq_pkg::PH_CONNECT);

  // An abort skips setup, so address and cycle type keep their old values;
  // phase one then carries the abort handling.
  // A pending call connects only once the previous call's restore is done
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      svc_q <= io_seq_pkg::PH_IDLE;
    end else begin
      case (svc_q)
        io_seq_pkg::PH_IDLE: begin
          if (sc_s)
            svc_q <= io_seq_pkg::PH_CONNECT;
        end
        io_seq_pkg::PH_CONNECT: begin
          if (ABORT_FLAG)
            svc_q <= io_seq_pkg::PH_MAIN;
          else if (rdy_s && CONTEXT_SAVED)
            svc_q <= io_seq_pkg::PH_SETUP;
        end
        io_seq_pkg::PH_SETUP: svc_q <= io_seq_pkg::PH_MAIN; // One clock long
        io_seq_pkg::PH_MAIN: begin
          if (sc_s && RESTORE_DONE)
            svc_q <= io_seq_pkg::PH_CONNECT;
          else if (RESTORE_DONE)
            svc_q <= io_seq_pkg::PH_IDLE;
        end
        default: svc_q <= io_seq_pkg::PH_IDLE;
      endcase
    end
  end

  // Cycle type recorded at setup from the order-read, data-out and I/O read conditions
  // It stands until the next setup, so later phases may still consult it
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST)
      CYCLE_TYPE <= 3'h0;
    else if (setup)
      CYCLE_TYPE <= {DATA_ORDER_READ, DATA_OUT_COND, IO_READ_COND};
  end

  // ==========================================================================
  // Channel address register
  // ==========================================================================
  logic addr_from_resp;
  logic addr_clear;
  assign addr_from_resp = setup || INTERRUPT_ACK_INSTRUCTION;
  assign addr_clear     = ADDRESS_FROM_ACCUMULATOR || addr_from_resp;
  // Both sources OR into the cleared field; the CPU never raises both together

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      CHANNEL_ADDRESS_REG <= `ADDR_RESET;
    end else begin
      if (addr_clear)
        CHANNEL_ADDRESS_REG[9:2] <=
          (ADDRESS_FROM_ACCUMULATOR ? ACCUM_BYTE : 8'h00) |
          (addr_from_resp ? resp_s : 8'h00);
      // Area bits are held clear through setup so area 0 is read first
      if (setup || AREA_CLEAR) begin
        CHANNEL_ADDRESS_REG[1:0] <= 2'h0;
      end else begin
        if (AREA_SET_HI)
          CHANNEL_ADDRESS_REG[1] <= 1'b1;
        if (AREA_SET_LO && PROCESSOR_OPTION_PRESENT)
          CHANNEL_ADDRESS_REG[0] <= 1'b1;
      end
    end
  end

  // Bit 9 of the register is address bit 0 (big-endian numbering)
  logic [7:0] a;
  assign a = CHANNEL_ADDRESS_REG[9:2];
  logic multi;
  assign multi = a[7];
  logic group_select_hi;
  logic group_select_lo;
  logic channel_select_2;
  logic channel_select_1;
  logic channel_select_0;
  // Multidevice controllers all sit in group 0, so both group selects drop
  assign group_select_hi  = a[4] & ~multi;
  assign group_select_lo  = a[3] & ~multi;
  assign channel_select_2 = multi ? a[6] : a[2];
  assign channel_select_1 = multi ? a[5] : a[1];
  assign channel_select_0 = multi ? a[4] : a[0];
  assign FAST_MEM_SELECT  = {group_select_hi, group_select_lo,
                             channel_select_2, channel_select_1, channel_select_0};
  // Area 0/1 address four bytes, 2/3 the single fifth byte
  assign FAST_MEM_AREA    = CHANNEL_ADDRESS_REG[1:0];

  // ==========================================================================
  // Outgoing byte register and parity
  // ==========================================================================
  // Lower bits load only from the accumulator; a terminal order leaves them alone
  logic byte_clear;
  assign byte_clear = BYTE_FROM_ACCUMULATOR || TERMINAL_ORDER_COND || setup;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      OUTGOING_BYTE_REG <= `BYTE_RESET;
    end else begin
      if (byte_clear)
        OUTGOING_BYTE_REG[7:4] <=
          (TERMINAL_ORDER_COND ? TERM_FLAG_BITS : 4'h0) |
          (BYTE_FROM_ACCUMULATOR ? ACCUM_BYTE[7:4] : 4'h0);
      if (BYTE_FROM_ACCUMULATOR)
        OUTGOING_BYTE_REG[3:0] <= ACCUM_BYTE[3:0];
    end
  end

  // ==========================================================================
  // Main phases and subphases
  // ==========================================================================
  logic [3:0]              ph_q;
  io_seq_pkg::subphase_t   sub_q;
  logic                    at_sub8;
  logic                    at_sub12;
  logic                    at_sub14;
  logic                    at_sub15;
  assign at_sub8  = (sub_q == `SUB_FIRST);
  assign at_sub12 = (sub_q == `SUB_TWELVE);
  assign at_sub14 = (sub_q == `SUB_FOURTEEN);
  assign at_sub15 = (sub_q == `SUB_LAST);

  logic count_zero;
  assign count_zero = INDICATORS[`IND_COUNT_ZERO];
  logic dchain;
  assign dchain = INDICATORS[`IND_CHAIN];

  // Phases are not strictly sequential: a phase flop stays set until its own
  // reset term, and more than one may stand at once when a set and the old
  // phase overlap. All of them share the one subphase counter, so a new
  // phase picks up wherever that counter stands.
  logic [3:0] ph_set;
  logic [3:0] ph_rst;
  logic       end2;
  assign end2 = count_zero & ph_q[2] & (at_sub14 | at_sub15);
  logic nvd;
  assign nvd = ph_q[0] & at_sub14 & DATA_OUT_COND & NO_VALID_DATA_OUT;
  always_comb begin
    ph_rst[0] = (IO_READ_COND & ph_q[0] & at_sub12) | (ph_q[0] & at_sub15) | nvd;
    ph_set[0] = setup | end2 | (ph_q[3] & at_sub15);
    ph_rst[1] = ph_q[1] & at_sub8 & dchain & CHAINING_COND;
    ph_set[1] = (ph_q[0] & at_sub15) | (ABORT_FLAG && svc_q == io_seq_pkg::PH_CONNECT)
                | nvd;
    ph_rst[2] = end2;
    ph_set[2] = ph_q[0] & at_sub12 & IO_READ_COND & ~DATA_ORDER_READ;
    ph_rst[3] = ph_q[3] & at_sub15;
    ph_set[3] = (ph_q[0] & at_sub12 & DATA_ORDER_READ & IO_READ_COND) | ph_rst[1];
  end

  // Each phase flop is its own latch; set dominates so entry is never lost
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST)
      ph_q <= 4'h0;
    else
      ph_q <= ph_set | (ph_q & ~ph_rst);
  end
  assign MAIN_PHASE = ph_q;

  // Branch bits: 8, 10, 11, 12, 13, 15 (bit 6 spare reserved as zero)
  // Setup counts as a branch to subphase 8, so no step can slip past it
  // while the address and the first phase are being loaded.
  logic any_branch;
  assign any_branch = |BRANCH_TERMS[5:0] | setup;
  assign SEQUENTIAL_STEP_ENABLE = ~any_branch & ~SYS_RST;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sub_q <= `SUB_FIRST;
    end else if (BRANCH_TERMS[0] || setup) begin
      sub_q <= `SUB_FIRST;
    end else if (BRANCH_TERMS[1]) begin
      sub_q <= `SUB_TEN;
    end else if (BRANCH_TERMS[2]) begin
      sub_q <= `SUB_ELEVEN;
    end else if (BRANCH_TERMS[3]) begin
      sub_q <= `SUB_TWELVE;
    end else if (BRANCH_TERMS[4]) begin
      sub_q <= `SUB_THIRTEEN;
    end else if (BRANCH_TERMS[5]) begin
      sub_q <= `SUB_LAST;
    end else if (|ph_q && !at_sub15) begin
      // Subphase 15 holds until a branch or a new setup moves it
      sub_q <= sub_q + 3'h1;
    end
  end

  always_comb begin
    SUBPHASE = 8'h00;
    SUBPHASE[sub_q] = 1'b1;
  end

  // ==========================================================================
  // Indicators and data parity
  // ==========================================================================
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST)
      INDICATORS <= `IND_RESET;
    else if (IND_LOAD)
      INDICATORS <= IND_VALUE;
  end
  // Indicators are loaded whole; the sequencer reads the count and chain bits and drives the end lines from bits 6 and 7
  assign END_DATA_LINE    = INDICATORS[`IND_END_DATA];
  assign END_SERVICE_LINE = INDICATORS[`IND_END_SVC];

  // The data-in error only sets; the next subphase-13 load in phase zero overwrites it with the data-out parity term,
  // so software must read it before that point.
  logic parity_generator_term;
  assign parity_generator_term = ~(^OUTGOING_BYTE_REG);
  logic in_bad;
  assign in_bad = ~(^{din_s, dpar_s});

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST)
      DATA_PARITY_LINE <= 1'b0;
    else if (ph_q[0] && sub_q == `SUB_THIRTEEN)
      DATA_PARITY_LINE <= DATA_OUT_COND & parity_generator_term;
    else if (ph_q[0] && at_sub14 && DATA_IN_COND && pchk_s && in_bad)
      DATA_PARITY_LINE <= 1'b1;
  end

endmodule : io_addr_data_sequencer

// ### bench/io_seq_checker.sv
// Assertion checker for the I/O address and phase sequencer
`timescale 1ns/1ps
module io_seq_checker (
  // Clock and reset
  input wire logic       SYS_CLK,
  input wire logic       SYS_RST,
  // Watched ports
  input wire logic [7:0] ACCUM_BYTE,
  input wire logic       ADDRESS_FROM_ACCUMULATOR,
  input wire logic       INTERRUPT_ACK_INSTRUCTION,
  input wire logic       PROCESSOR_OPTION_PRESENT,
  input wire logic [6:0] BRANCH_TERMS,
  input wire logic       IND_LOAD,
  input wire logic [7:0] IND_VALUE,
  input wire logic [9:0] CHANNEL_ADDRESS_REG,
  input wire logic [4:0] FAST_MEM_SELECT,
  input wire logic [1:0] FAST_MEM_AREA,
  input wire logic [3:0] MAIN_PHASE,
  input wire logic [7:0] SUBPHASE,
  input wire logic       SETUP_PHASE_TERM,
  input wire logic       SEQUENTIAL_STEP_ENABLE,
  input wire logic [7:0] INDICATORS
);
  // ==========================================
  // Properties
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  sel_single_a: assert property (
    !CHANNEL_ADDRESS_REG[9] |-> FAST_MEM_SELECT == CHANNEL_ADDRESS_REG[6:2])
    else $error("single-device select wrong");
  sel_multi_a: assert property (
    CHANNEL_ADDRESS_REG[9] |-> FAST_MEM_SELECT == {2'h0, CHANNEL_ADDRESS_REG[8:6]})
    else $error("multidevice select wrong");
  area_option_a: assert property (
    $rose(FAST_MEM_AREA[0]) |-> $past(PROCESSOR_OPTION_PRESENT))
    else $error("low area bit set without option");
  addr_load_a: assert property (
    ADDRESS_FROM_ACCUMULATOR && !INTERRUPT_ACK_INSTRUCTION && !SETUP_PHASE_TERM
    |=> CHANNEL_ADDRESS_REG[9:2] == $past(ACCUM_BYTE)) else $error("address not replaced");
  ind_load_a: assert property (
    IND_LOAD |=> INDICATORS == $past(IND_VALUE)) else $error("indicators not loaded");
  step_gate_a: assert property (
    SEQUENTIAL_STEP_ENABLE |-> BRANCH_TERMS[5:0] == 6'h00) else $error("step during branch");
  setup_entry_a: assert property (
    SETUP_PHASE_TERM |=> MAIN_PHASE[0] && SUBPHASE == 8'h01 && !SETUP_PHASE_TERM)
    else $error("setup did not enter phase zero");
  reset_clear_a: assert property (
    $fell(SYS_RST) |-> MAIN_PHASE == 4'h0 && SUBPHASE == 8'h01)
    else $error("phases not cleared by reset");

  setup_c: cover property (SETUP_PHASE_TERM);
  multi_c: cover property (CHANNEL_ADDRESS_REG[9]);
  branch_c: cover property (MAIN_PHASE[1] && SUBPHASE[4]);
endmodule : io_seq_checker

bind io_addr_data_sequencer io_seq_checker watch (.*);

// ### bench/ctl_model.sv
// Device controller model facing the sequencer pins
`timescale 1ns/1ps
module ctl_model (
  // Clock and bench control
  input  wire logic       SYS_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       req,
  input  wire logic       bad_par,
  input  wire logic [7:0] addr,
  // Controller pins
  input  wire logic       SERVICE_CALL_ACK,
  output logic            SERVICE_CALL,
  output logic            CONTROLLER_READY,
  output logic [7:0]      FUNCTION_RESPONSE_LINES,
  output logic [7:0]      IN_DATA_LINES,
  output logic            IN_PARITY_LINE,
  output logic            PARITY_CHECK_REQ
);
  logic ack_q;
  // ==========================================
  // Pin behaviour
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      {ack_q, SERVICE_CALL, CONTROLLER_READY, PARITY_CHECK_REQ} <= 4'h0;
      {FUNCTION_RESPONSE_LINES, IN_DATA_LINES} <= 16'h0000;
      IN_PARITY_LINE <= 1'b1;
    end else begin
      ack_q <= req & (ack_q | SERVICE_CALL_ACK);
      SERVICE_CALL <= req;
      CONTROLLER_READY <= ack_q;
      // Released lines flip each cycle so a late capture cannot look right
      FUNCTION_RESPONSE_LINES <= ack_q ? addr : ~FUNCTION_RESPONSE_LINES;
      IN_DATA_LINES <= ~IN_DATA_LINES;
      // The bench may corrupt the parity bit to trip the data-in check
      IN_PARITY_LINE <= (~^IN_DATA_LINES) ^ bad_par;
      PARITY_CHECK_REQ <= 1'b1;
    end
  end
endmodule : ctl_model

// ### bench/testbench.sv
// Self-checking bench for the I/O address and phase sequencer
`timescale 1ns/1ps
module testbench;
  logic       SYS_CLK, SYS_RST, req, bad_par, IND_LOAD, SERVICE_CALL, CONTROLLER_READY;
  logic       ADDRESS_FROM_ACCUMULATOR, INTERRUPT_ACK_INSTRUCTION, BYTE_FROM_ACCUMULATOR;
  logic       TERMINAL_ORDER_COND, AREA_SET_HI, AREA_SET_LO, AREA_CLEAR, RESTORE_DONE;
  logic       PROCESSOR_OPTION_PRESENT, CONTEXT_SAVED, IO_READ_COND, DATA_ORDER_READ;
  logic       DATA_OUT_COND, DATA_IN_COND, NO_VALID_DATA_OUT, CHAINING_COND, ABORT_FLAG;
  logic       IN_PARITY_LINE, PARITY_CHECK_REQ, DATA_PARITY_LINE, SERVICE_CALL_ACK;
  logic       END_DATA_LINE, END_SERVICE_LINE, SETUP_PHASE_TERM, SEQUENTIAL_STEP_ENABLE;
  logic [1:0] FAST_MEM_AREA;
  logic [2:0] CYCLE_TYPE;
  logic [3:0] TERM_FLAG_BITS, MAIN_PHASE;
  logic [4:0] FAST_MEM_SELECT;
  logic [6:0] BRANCH_TERMS;
  logic [7:0] ACCUM_BYTE, FUNCTION_RESPONSE_LINES, IN_DATA_LINES, IND_VALUE, addr;
  logic [7:0] OUTGOING_BYTE_REG, SUBPHASE, INDICATORS;
  logic [9:0] CHANNEL_ADDRESS_REG;
  logic [7:0] tv [3] = '{8'hff, 8'h5a, 8'h95};
  // Each entry: option, clear, set high, set low, expected area
  logic [5:0] at [4] = '{6'h04, 6'h0a, 6'h27, 6'h30};
  int         err_count = 0;
  int         tests_run = 0;
  int         n;

  io_addr_data_sequencer uut (.*);
  ctl_model far_end (.*);

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic do_reset(input int cycles);
    SYS_RST <= 1'b1;
    repeat (cycles) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    @(negedge SYS_CLK);
    chk(MAIN_PHASE, 4'h0);
    chk(SUBPHASE, 8'h01);
  endtask : do_reset

  // Waits for the setup clock, then drops the call request after it
  task automatic wait_setup;
    n = 0;
    while (SETUP_PHASE_TERM !== 1'b1 && n < 40) begin
      @(negedge SYS_CLK);
      n++;
    end
    if (SETUP_PHASE_TERM !== 1'b1) begin
      err_count++;
      close_out();
    end
    @(posedge SYS_CLK);
    req <= 1'b0;
    @(negedge SYS_CLK);
  endtask : wait_setup

  // ==========================================
  // Main sequence
  initial begin
    {ADDRESS_FROM_ACCUMULATOR, INTERRUPT_ACK_INSTRUCTION, BYTE_FROM_ACCUMULATOR,
     TERMINAL_ORDER_COND, AREA_SET_HI, AREA_SET_LO, AREA_CLEAR, PROCESSOR_OPTION_PRESENT,
     IO_READ_COND, DATA_ORDER_READ, DATA_OUT_COND, DATA_IN_COND, NO_VALID_DATA_OUT,
     CHAINING_COND, ABORT_FLAG, RESTORE_DONE, IND_LOAD, req, bad_par} = '0;
    {ACCUM_BYTE, IND_VALUE, addr, TERM_FLAG_BITS, BRANCH_TERMS} = '0;
    CONTEXT_SAVED = 1'b1;
    SYS_RST = 1'b1;
    do_reset(20);
    chk(SEQUENTIAL_STEP_ENABLE, 1'b1);
    // Reloads that drop ones of the old value show whether old bits are cleared first
    foreach (tv[i]) begin
      @(posedge SYS_CLK);
      ACCUM_BYTE <= tv[i];
      ADDRESS_FROM_ACCUMULATOR <= 1'b1;
      @(posedge SYS_CLK);
      ADDRESS_FROM_ACCUMULATOR <= 1'b0;
      @(negedge SYS_CLK);
      chk(CHANNEL_ADDRESS_REG[9:2], tv[i]);
      chk(FAST_MEM_SELECT, tv[i][7] ? {2'h0, tv[i][6:4]} : tv[i][4:0]);
    end
    foreach (at[i]) begin
      @(posedge SYS_CLK);
      {PROCESSOR_OPTION_PRESENT, AREA_CLEAR, AREA_SET_HI, AREA_SET_LO} <= at[i][5:2];
      @(posedge SYS_CLK);
      {AREA_CLEAR, AREA_SET_HI, AREA_SET_LO} <= 3'h0;
      @(negedge SYS_CLK);
      chk(FAST_MEM_AREA, at[i][1:0]);
    end
    @(posedge SYS_CLK);
    ACCUM_BYTE <= 8'h3c;
    IND_VALUE <= 8'hc1;
    {BYTE_FROM_ACCUMULATOR, IND_LOAD} <= 2'h3;
    @(posedge SYS_CLK);
    {BYTE_FROM_ACCUMULATOR, IND_LOAD} <= 2'h0;
    @(negedge SYS_CLK);
    chk(OUTGOING_BYTE_REG, 8'h3c);
    chk(INDICATORS, 8'hc1);
    chk({END_SERVICE_LINE, END_DATA_LINE}, 2'h3);
    // Data-out service call from a multidevice controller
    @(posedge SYS_CLK);
    addr <= 8'h9c;
    DATA_OUT_COND <= 1'b1;
    req <= 1'b1;
    wait_setup();
    chk(MAIN_PHASE, 4'h1);
    chk(FAST_MEM_SELECT, 5'h01);
    chk(SUBPHASE, 8'h01);
    chk(CHANNEL_ADDRESS_REG[9:2], 8'h9c);
    chk(CYCLE_TYPE, 3'h2);
    chk(OUTGOING_BYTE_REG, 8'h0c);
    repeat (7) @(negedge SYS_CLK);
    chk(SUBPHASE, 8'h80);
    chk(DATA_PARITY_LINE, 1'b1);
    @(negedge SYS_CLK);
    chk(MAIN_PHASE, 4'h2);
    @(posedge SYS_CLK);
    BRANCH_TERMS <= 7'h08;
    @(negedge SYS_CLK);
    chk(SEQUENTIAL_STEP_ENABLE, 1'b0);
    @(posedge SYS_CLK);
    BRANCH_TERMS <= 7'h00;
    @(negedge SYS_CLK);
    chk(SUBPHASE, 8'h10);
    @(posedge SYS_CLK);
    do_reset(2);
    // Data-in call whose controller corrupts the parity bit
    @(posedge SYS_CLK);
    {DATA_OUT_COND, DATA_IN_COND, bad_par, req} <= 4'h7;
    addr <= 8'h2b;
    wait_setup();
    chk(FAST_MEM_SELECT, 5'h0b);
    repeat (6) @(negedge SYS_CLK);
    chk(DATA_PARITY_LINE, 1'b0);
    @(negedge SYS_CLK);
    chk(DATA_PARITY_LINE, 1'b1);
    close_out();
  end
endmodule : testbench
